//--- inc/adcc_defines.vh
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADCC_ADDR_CTRL      8'hC0
`define ADCC_ADDR_P0DIS     8'hC4
`define ADCC_ADDR_RESULT    8'hC8
`define ADCC_ADDR_CFG       8'hCC
`define ADCC_ADDR_P0READ    8'hD0

// ****************************************
// Control register fields
// ****************************************
`define ADCC_CTRL_PWR       7
`define ADCC_CTRL_DONE      4
`define ADCC_CTRL_BUSY      3
`define ADCC_CTRL_RCSEL     2
`define ADCC_CTRL_CH_HI     1
`define ADCC_CTRL_CH_LO     0
`define ADCC_CTRL_RESET     8'h00

// ****************************************
// Config register fields
// ****************************************
`define ADCC_CFG_GIE        0
`define ADCC_CFG_IRQEN      1
`define ADCC_CFG_STDTIME    2
`define ADCC_CFG_RESET      8'h00
`define ADCC_CFG_MASK       8'h07
`define ADCC_P0DIS_RESET    8'h00

// ****************************************
// Timing counts
// ****************************************
`define ADCC_OSC_PER_MC     6
`define ADCC_OSC_PER_MC_STD 12
`define ADCC_CPU_MC_CONV    31
`define ADCC_RC_SYNC_MC     3
`define ADCC_RC_PERIODS     108
`define ADCC_RES_BITS       8

`endif

//--- design/adcc_mcyc.v
`timescale 1ns/1ps
`include "adcc_defines.vh"

// ****************************************
// Machine-cycle enable divider
// ****************************************
module adcc_mcyc
#(
  parameter NORM_DIV = `ADCC_OSC_PER_MC,
  parameter STD_DIV  = `ADCC_OSC_PER_MC_STD
)
(
  input  wire       i_sys_clk,   // Oscillator clock
  input  wire       i_rst,       // Sync reset, high
  input  wire       i_std_time,  // Standard timing option
  output wire       o_mc_tick    // One pulse per machine cycle
);

  reg  [3:0] cnt_r;
  wire [3:0] last;

  assign last      = i_std_time ? STD_DIV[3:0] - 4'h1 : NORM_DIV[3:0] - 4'h1;
  assign o_mc_tick = (cnt_r >= last);

  // Free-running count; >= recovers when option flips mid-cycle
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      cnt_r <= 4'h0;
    else if (o_mc_tick)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end

endmodule

//--- design/adcc_sar.v
`timescale 1ns/1ps
`include "adcc_defines.vh"

// ****************************************
// Successive-approximation sequencer
// ****************************************
module adcc_sar
#(
  parameter BITS     = `ADCC_RES_BITS,
  parameter CPU_MC   = `ADCC_CPU_MC_CONV,
  parameter SYNC_MC  = `ADCC_RC_SYNC_MC,
  parameter RC_STEPS = `ADCC_RC_PERIODS
)
(
  input  wire            i_sys_clk,  // System clock
  input  wire            i_rst,      // Sync reset, high
  input  wire            i_start,    // Start pulse
  input  wire            i_rc_mode,  // Step on RC ticks
  input  wire            i_mc_tick,  // Machine-cycle enable
  input  wire            i_rc_tick,  // RC oscillator enable
  input  wire            i_cmp,      // High when input above trial level
  output reg  [BITS-1:0] o_trial,    // Trial code to the DAC
  output reg  [BITS-1:0] o_result,   // Final code
  output reg             o_done      // One-cycle completion pulse
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SYNC = 2'd1;
  localparam ST_CONV = 2'd2;

  reg [1:0]      state_r;
  reg            rc_r;
  reg [6:0]      step_r;
  reg [BITS-1:0] mask_r;
  wire           step_en;
  wire [6:0]     step_last;

  assign step_en   = rc_r ? i_rc_tick : i_mc_tick;
  assign step_last = rc_r ? RC_STEPS[6:0] : CPU_MC[6:0];

  // Sequencer: one bit decided per step, then pad to full length
  always @(posedge i_sys_clk)
  begin
    o_done <= 1'b0;
    if (i_rst)
    begin
      state_r  <= ST_IDLE;
      rc_r     <= 1'b0;
      step_r   <= 7'h00;
      mask_r   <= {BITS{1'b0}};
      o_trial  <= {BITS{1'b0}};
      o_result <= {BITS{1'b0}};
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          // Park at midscale so the comparator has settled before the first decision
          o_trial <= {1'b1, {(BITS-1){1'b0}}};
          if (i_start)
          begin
            rc_r    <= i_rc_mode;
            step_r  <= 7'h00;
            mask_r  <= {1'b1, {(BITS-1){1'b0}}};
            state_r <= i_rc_mode ? ST_SYNC : ST_CONV;
          end
        end
        ST_SYNC:
        begin
          if (i_mc_tick)
          begin
            step_r <= step_r + 7'h01;
            if (step_r == SYNC_MC[6:0] - 7'h01)
            begin
              step_r  <= 7'h00;
              state_r <= ST_CONV;
            end
          end
        end
        ST_CONV:
        begin
          if (step_en)
          begin
            step_r <= step_r + 7'h01;
            if (mask_r != {BITS{1'b0}})
            begin
              o_trial <= (i_cmp ? o_trial : (o_trial & ~mask_r)) | (mask_r >> 1);
              mask_r  <= mask_r >> 1;
            end
            if (step_r == step_last - 7'h01)
            begin
              o_result <= o_trial;
              o_done   <= 1'b1;
              state_r  <= ST_IDLE;
            end
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- design/adcc_top.v
`timescale 1ns/1ps
`include "adcc_defines.vh"

// ****************************************
// Converter control block
// ****************************************
// Function
// - One shared converter turns one of four channels into 8 bits.
// - Control holds power b7, done b4, busy b3, RC b2, channel b1:0.
// - Channel bits frozen while a conversion runs.
// - Busy bit reads one for the whole conversion.
// - At end, busy clears and done sets.
// - Interrupt request while done, global enable and converter enable set.
// - Result loads at completion and holds until the next completion.
// - Only a software zero write clears done.
// - Starts ignored while busy or done is one.
// - Start write may load a new channel for that conversion.
// - Done-clearing write leaves channel unchanged.
// - Result is input times 256 over supply span, rounded.
// - Port 0 disable bits gate off pin digital inputs.
// - Disabled port 0 pins read as zero.
// - Machine cycle is 6 clocks, 12 with standard timing.
// - CPU-clocked conversion takes 31 machine cycles.
// - RC mode takes sync machine cycles plus 108 RC periods.
// - Done zero busy one means running; both zero means idle.
module adcc_top
#(
  parameter RES_BITS = `ADCC_RES_BITS,
  parameter CPU_MC   = `ADCC_CPU_MC_CONV,
  parameter SYNC_MC  = `ADCC_RC_SYNC_MC,
  parameter RC_STEPS = `ADCC_RC_PERIODS
)
(
  input  wire                i_sys_clk,     // 125 MHz clock
  input  wire                i_rst,         // Sync reset, high
  input  wire                i_wb_cyc,      // Wishbone cycle
  input  wire                i_wb_stb,      // Wishbone strobe
  input  wire                i_wb_we,       // Write enable
  input  wire [7:0]          i_wb_adr,      // Byte address
  input  wire [3:0]          i_wb_sel,      // Byte lanes
  input  wire [31:0]         i_wb_dat,      // Write data
  output reg  [31:0]         o_wb_dat,      // Read data
  output reg                 o_wb_ack,      // Acknowledge
  input  wire                i_rc_tick,     // RC oscillator enable pulse
  input  wire                i_cmp,         // Comparator result
  input  wire [7:0]          i_port0_pins,  // Raw port 0 pin levels
  output wire [7:0]          o_port0_in_en, // Per-pin digital input enable
  output wire                o_adc_power,   // Converter power on
  output reg  [1:0]          o_chan_sel,    // Analog mux select
  output wire [RES_BITS-1:0] o_trial_code,  // DAC trial code
  output reg                 o_irq_req      // Converter interrupt request
);

  // ****************************************
  // Reset values
  // ****************************************

  // Control reset word, sliced so each flop takes its own field
  localparam [7:0] CTRL_RST = `ADCC_CTRL_RESET;

  // ****************************************
  // Registers and wires
  // ****************************************
  // Control and config storage
  reg                 pwr_r;
  reg                 done_r;
  reg                 busy_r;
  reg                 rcsel_r;
  reg  [7:0]          p0dis_r;
  reg  [7:0]          cfg_r;
  reg  [RES_BITS-1:0] result_r;
  reg                 start_r;
  // Next-state terms
  reg  [31:0]         rd_nxt;
  reg                 done_nxt;
  reg                 busy_nxt;
  reg  [1:0]          chan_nxt;
  reg                 start_nxt;
  // Decode, status and sequencer links
  wire                wr_ctrl;
  wire                wr_go;
  wire                mc_tick;
  wire                seq_done;
  wire [RES_BITS-1:0] seq_result;
  wire [7:0]          ctrl_rd;
  wire [7:0]          wd;
  wire                hit_ctrl;
  wire                hit_p0dis;
  wire                hit_cfg;
  wire                conv_idle;

  // ****************************************
  // Wishbone slave
  // ****************************************

  // One hit per writable register; all of them live in byte lane 0
  assign hit_ctrl  = (i_wb_adr == `ADCC_ADDR_CTRL);
  assign hit_p0dis = (i_wb_adr == `ADCC_ADDR_P0DIS);
  assign hit_cfg   = (i_wb_adr == `ADCC_ADDR_CFG);

  // Writes land on the ack edge, so data is stable one cycle ahead
  assign wr_go   = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0];
  assign wr_ctrl = wr_go & hit_ctrl;
  assign wd      = i_wb_dat[7:0];

  // control bit layout
  // Reserved bits 6:5 read zero so software cannot mistake them for state
  assign ctrl_rd = {pwr_r, 2'b00, done_r, busy_r, rcsel_r, o_chan_sel};

  // Read mux; unmapped addresses read zero
  // Sampled with the request, so a read shows state one edge before ack
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    case (i_wb_adr)
      `ADCC_ADDR_CTRL:   rd_nxt[7:0] = ctrl_rd;
      `ADCC_ADDR_P0DIS:  rd_nxt[7:0] = p0dis_r;
      `ADCC_ADDR_RESULT: rd_nxt[RES_BITS-1:0] = result_r;
      `ADCC_ADDR_CFG:    rd_nxt[7:0] = cfg_r;
      `ADCC_ADDR_P0READ: rd_nxt[7:0] = i_port0_pins & ~p0dis_r;
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  // One wait state; ack drops the cycle after it is given
  // A master that gives up early just loses the ack; nothing is left pending
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      if (i_wb_cyc & i_wb_stb & ~o_wb_ack)
        o_wb_dat <= rd_nxt;
    end
  end

  // ****************************************
  // Control register next state
  // ****************************************

  // both flags low means idle and startable
  assign conv_idle = ~busy_r & ~done_r;

  // Flag, busy and channel updates from software and sequencer
  always @*
  begin
    done_nxt  = done_r;
    busy_nxt  = busy_r;
    chan_nxt  = o_chan_sel;
    start_nxt = 1'b0;
    if (wr_ctrl)
    begin
      if (!wd[`ADCC_CTRL_DONE])
        done_nxt = 1'b0;
      if (!busy_r && !(done_r && !wd[`ADCC_CTRL_DONE]))
        chan_nxt = wd[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
      // start ignored while busy or done
      if (wd[`ADCC_CTRL_BUSY] && conv_idle)
      begin
        // same write may pick the channel
        chan_nxt  = wd[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
        busy_nxt  = 1'b1;
        start_nxt = 1'b1;
      end
    end
    // Hazard: a write and the done pulse may meet in one cycle; the pulse is applied last
    // completion clears busy, sets done
    // set wins over a same-cycle clear
    if (seq_done)
    begin
      done_nxt = 1'b1;
      busy_nxt = 1'b0;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************

  // control resets to zero
  // Channel code drives the analog mux directly, code n picks input n
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pwr_r      <= CTRL_RST[`ADCC_CTRL_PWR];
      rcsel_r    <= CTRL_RST[`ADCC_CTRL_RCSEL];
      done_r     <= CTRL_RST[`ADCC_CTRL_DONE];
      busy_r     <= CTRL_RST[`ADCC_CTRL_BUSY];
      o_chan_sel <= CTRL_RST[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
      start_r    <= 1'b0;
      p0dis_r    <= `ADCC_P0DIS_RESET;
      cfg_r      <= `ADCC_CFG_RESET;
    end
    else
    begin
      done_r     <= done_nxt;
      busy_r     <= busy_nxt;
      o_chan_sel <= chan_nxt;
      start_r    <= start_nxt;
      // Power and RC select have no side effects, so any control write updates them
      if (wr_ctrl)
      begin
        pwr_r   <= wd[`ADCC_CTRL_PWR];
        rcsel_r <= wd[`ADCC_CTRL_RCSEL];
      end
      if (wr_go && hit_p0dis)
        p0dis_r <= wd;
      // Config bits 7:3 are not implemented and read zero
      if (wr_go && hit_cfg)
        cfg_r <= wd & `ADCC_CFG_MASK;
    end
  end

  // ****************************************
  // Result and interrupt
  // ****************************************

  // Result kept apart from the trial code so reads never see a half-built value
  // result loads only on completion
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      result_r <= {RES_BITS{1'b0}};
    else if (seq_done)
      result_r <= seq_result;
  end

  // request gated by both enables; priority lives outside
  // Built from done_nxt so the request rises with the flag, not a cycle later
  always @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_irq_req <= 1'b0;
    else
      o_irq_req <= done_nxt & cfg_r[`ADCC_CFG_GIE] & cfg_r[`ADCC_CFG_IRQEN];
  end

  // ****************************************
  // Pin-facing outputs
  // ****************************************

  // set bit turns the digital input off
  assign o_port0_in_en = ~p0dis_r;
  // software keeps the power lead time; not enforced here
  assign o_adc_power   = pwr_r;

  // ****************************************
  // Machine-cycle divider
  // ****************************************
  // Divider runs free, so a start may land anywhere inside a machine cycle
  // machine cycle from the option bit
  adcc_mcyc u_mcyc
  (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_std_time (cfg_r[`ADCC_CFG_STDTIME]),
    .o_mc_tick  (mc_tick)
  );

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // The sequencer owns conversion timing; this block launches it and collects the code
  // rounding relies on half-LSB offset in the analog DAC
  adcc_sar
  #(
    .BITS     (RES_BITS),
    .CPU_MC   (CPU_MC),
    .SYNC_MC  (SYNC_MC),
    .RC_STEPS (RC_STEPS)
  )
  u_sar
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_start   (start_r),
    .i_rc_mode (rcsel_r),
    .i_mc_tick (mc_tick),
    .i_rc_tick (i_rc_tick),
    .i_cmp     (i_cmp),
    .o_trial   (o_trial_code),
    .o_result  (seq_result),
    .o_done    (seq_done)
  );

endmodule

//--- verif/adcc_chk.sv
`timescale 1ns/1ps

// ****************************************
// Port-level checker for the converter block
// ****************************************
module adcc_chk
#(
  parameter RES_BITS = 8
)
(
  input wire                i_sys_clk,     // Clock
  input wire                i_rst,         // Reset
  input wire                i_wb_cyc,      // Cycle
  input wire                i_wb_stb,      // Strobe
  input wire                i_wb_we,       // Write
  input wire [7:0]          i_wb_adr,      // Address
  input wire [3:0]          i_wb_sel,      // Lanes
  input wire [31:0]         i_wb_dat,      // Write data
  input wire [31:0]         o_wb_dat,      // Read data
  input wire                o_wb_ack,      // Ack
  input wire                i_rc_tick,     // RC tick
  input wire                i_cmp,         // Comparator
  input wire [7:0]          i_port0_pins,  // Pins
  input wire [7:0]          o_port0_in_en, // Input enable
  input wire                o_adc_power,   // Power
  input wire [1:0]          o_chan_sel,    // Channel
  input wire [RES_BITS-1:0] o_trial_code,  // Trial
  input wire                o_irq_req      // Interrupt
);
  // Accepted write and its low byte
  wire       wr_ack = o_wb_ack && i_wb_we && i_wb_sel[0];
  wire [7:0] wbyte  = i_wb_dat[7:0];
  wire       pbit   = i_wb_dat[7];

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ****************************************
  // Bus timing and register effects
  // ****************************************
  AST_ACK_WAIT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  AST_ACK_DROP: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  AST_HI_ZERO: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_P0_WR: assert property (wr_ack && i_wb_adr == 8'hC4 |=> o_port0_in_en == ~$past(wbyte))
    else $error("input enable wrong");
  AST_P0_HOLD: assert property (!(wr_ack && i_wb_adr == 8'hC4) |=> $stable(o_port0_in_en))
    else $error("input enable moved");
  AST_P0_READ: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 8'hD0
    |-> o_wb_dat[7:0] == ($past(i_port0_pins) & $past(o_port0_in_en))) else $error("gated read wrong");
  AST_PWR_WR: assert property (wr_ack && i_wb_adr == 8'hC0 |=> o_adc_power == $past(pbit))
    else $error("power bit wrong");
  AST_CHAN_HOLD: assert property (!(wr_ack && i_wb_adr == 8'hC0) |=> $stable(o_chan_sel))
    else $error("channel moved");
  // Irq falls one edge after the clearing write
  AST_IRQ_HOLD: assert property (o_irq_req && !wr_ack && !$past(wr_ack) |=> o_irq_req)
    else $error("irq dropped");

  COV_CTRL_WR: cover property (wr_ack && i_wb_adr == 8'hC0);
  COV_IRQ: cover property ($rose(o_irq_req));
  COV_P0_RD: cover property (o_wb_ack && i_wb_adr == 8'hD0);
endmodule

//--- verif/adcc_top_tb.sv
`timescale 1ns/1ps

// ****************************************
// Self-checking bench for the converter block
// ****************************************
module adcc_top_tb;
  // Short conversion so the run stays brief
  localparam CPU_MC = 9;
  localparam RC_N   = 9;
  localparam SYNC   = 3;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic        rct = 1'b0;
  logic        cmp = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  pins = 8'h00;
  logic [7:0]  vin = 8'h00;
  logic [7:0]  d;
  logic [7:0]  e;
  logic [3:0]  sel = 4'h0;
  logic [2:0]  rcd = 3'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  wire  [31:0] rdat;
  wire         ack;
  wire         pwr;
  wire         irq;
  wire  [1:0]  chan;
  wire  [7:0]  en;
  wire  [7:0]  trial;
  integer      n_errors = 0;
  integer      n_tests = 0;
  integer      cnt = 0;
  integer      t0;
  integer      ch;
  integer      mc;
  integer      k;
  integer      r;

  adcc_top #(.CPU_MC(CPU_MC), .SYNC_MC(SYNC), .RC_STEPS(RC_N)) u_adcc_top (
    .i_sys_clk     (clk),
    .i_rst         (rst),
    .i_wb_cyc      (cyc),
    .i_wb_stb      (stb),
    .i_wb_we       (we),
    .i_wb_adr      (adr),
    .i_wb_sel      (sel),
    .i_wb_dat      (wdat),
    .o_wb_dat      (rdat),
    .o_wb_ack      (ack),
    .i_rc_tick     (rct),
    .i_cmp         (cmp),
    .i_port0_pins  (pins),
    .o_port0_in_en (en),
    .o_adc_power   (pwr),
    .o_chan_sel    (chan),
    .o_trial_code  (trial),
    .o_irq_req     (irq)
  );

  always #4 clk = ~clk;

  // Cycle count, RC tick every 5 clocks, ideal comparator
  always @(posedge clk)
  begin
    cnt <= cnt + 1;
    rcd <= (rcd == 3'h4) ? 3'h0 : rcd + 3'h1;
    rct <= (rcd == 3'h0);
    cmp <= (trial <= vin);
  end

  task stop_test;
    begin
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    begin
      n_tests++;
      if (s !== x)
      begin
        n_errors++;
        $display("[FAIL] %s exp %h seen %h", n, x, s);
      end
    end
  endtask

  // One classic cycle; held until ack is sampled
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] dv);
    integer j;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, dv};
      sel <= 4'hF;
      j = 0;
      do
      begin
        @(posedge clk);
        j++;
      end
      while (ack !== 1'b1 && j < 40);
      if (j >= 40)
      begin
        n_errors++;
        stop_test;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // Idle edge: bus gap, and the write has landed before the caller looks
      @(posedge clk);
    end
  endtask

  // Bounded wait for the interrupt level
  task wait_irq;
    begin
      k = 0;
      while (irq !== 1'b1 && k < 1000)
      begin
        @(posedge clk);
        k++;
      end
      if (k >= 1000)
      begin
        n_errors++;
        stop_test;
      end
    end
  endtask

  initial
  begin
    r = $urandom(32'hFC6D);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // ****************************************
    // Reset values, unmapped space
    // ****************************************
    for (ch = 0; ch < 4; ch++)
    begin
      xfer(1'b0, 8'hC0 + 8'(ch * 4), 8'h00);
      chk("reset", q, 32'h0);
    end
    chk("in_en reset", {24'h0, en}, 32'hFF);
    xfer(1'b1, 8'hE0, 8'hFF);
    xfer(1'b0, 8'hE0, 8'h00);
    chk("unmapped", q, 32'h0);
    // Random port 0 gating
    repeat (4)
    begin
      d = 8'($urandom);
      pins <= 8'($urandom);
      xfer(1'b1, 8'hC4, d);
      xfer(1'b0, 8'hD0, 8'h00);
      chk("p0 read", q, {24'h0, pins & ~d});
      chk("in_en", {24'h0, en}, {24'h0, ~d});
    end
    // Power first, then settle time before any start
    xfer(1'b1, 8'hC0, 8'h80);
    chk("power", {31'h0, pwr}, 32'h1);
    repeat (1250) @(posedge clk);
    // ****************************************
    // CPU-clocked conversions, all channels
    // ****************************************
    for (ch = 0; ch < 4; ch++)
    begin
      e = (ch == 0) ? 8'h00 : (ch == 3) ? 8'hFF : 8'($urandom);
      vin <= e;
      mc = ch[0] ? 12 : 6;
      xfer(1'b1, 8'hCC, {5'h0, ch[0], 2'h3});
      xfer(1'b1, 8'hC0, 8'h88 | 8'(ch));
      t0 = cnt;
      xfer(1'b0, 8'hC0, 8'h00);
      chk("busy", q, 32'h88 | ch);
      // Channel change and restart while busy
      xfer(1'b1, 8'hC0, 8'h88 | 8'(ch ^ 3));
      chk("chan frozen", {30'h0, chan}, ch);
      wait_irq;
      chk("conv time", (cnt - t0 >= (CPU_MC - 1) * mc) && (cnt - t0 <= CPU_MC * mc + 4), 1);
      xfer(1'b0, 8'hC0, 8'h00);
      chk("done", q, 32'h90 | ch);
      xfer(1'b0, 8'hC8, 8'h00);
      chk("result", q, {24'h0, e});
      chk("irq on", {31'h0, irq}, 32'h1);
      // Start while done is ignored
      xfer(1'b1, 8'hC0, 8'h98 | 8'(ch));
      xfer(1'b0, 8'hC0, 8'h00);
      chk("start blocked", q, 32'h90 | ch);
      vin <= ~e;
      xfer(1'b0, 8'hC8, 8'h00);
      chk("result held", q, {24'h0, e});
      // Clearing write keeps channel
      xfer(1'b1, 8'hC0, 8'h80 | 8'(ch ^ 1));
      xfer(1'b0, 8'hC0, 8'h00);
      chk("clear done", q, 32'h80 | ch);
      chk("irq off", {31'h0, irq}, 32'h0);
    end
    // ****************************************
    // RC-clocked conversion with irq masked
    // ****************************************
    e = 8'($urandom);
    vin <= e;
    xfer(1'b1, 8'hCC, 8'h01);
    xfer(1'b1, 8'hC0, 8'h8E);
    t0 = cnt;
    q = 32'h0;
    for (k = 0; k < 100 && q[4] !== 1'b1; k++)
      xfer(1'b0, 8'hC0, 8'h00);
    chk("rc done", q, 32'h96);
    chk("rc time", (cnt - t0 >= SYNC * 6 + (RC_N - 1) * 5) && (cnt - t0 <= (SYNC + 1) * 6 + (RC_N + 1) * 5 + 6), 1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, 8'hCC, 8'h03);
    @(posedge clk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    xfer(1'b0, 8'hC8, 8'h00);
    chk("rc result", q, {24'h0, e});
    stop_test;
  end
endmodule

bind adcc_top adcc_chk #(.RES_BITS(RES_BITS)) u_adcc_chk (.*);
